//--- hw/timer_register_access_low_power.sv
// byte-wide register access, capture, compare and low-power logic of a 16-bit timer
`timescale 1ns/1ps
// Operation
// - counter high read freezes returned low byte until low byte read
// - low byte read after status read with overflow set clears overflow
// - writes to counter bytes are ignored
// - alternate high read freezes alternate low byte until it is read
// - alternate low read never touches overflow flag
// - writes to alternate counter bytes are ignored
// - selected edge on capture pin copies 16-bit count to capture bytes
// - capture high read blocks pin captures until capture low read; an armed stop-exit copy still lands
// - capture low read after status read with flag set clears capture flag
// - writes to capture bytes are ignored
// - counter equal to compare value performs compare pin action
// - compare high write suspends matching until compare low written
// - compare low read or write after status read clears compare flag
// - in wait mode the timer keeps counting and detecting events
// - enabled timer interrupt in wait mode wakes the processor
// - stop mode freezes the counter; interrupt exit resumes from it
// - stop ended by reset loads counter with fffc
// - capture edge in stop only arms detector, no flag, no wake
// - interrupt exit after arming shows capture flag and first-edge count
// - reset exit from stop discards any armed capture
// - counter wrap from ffff to 0000 sets overflow flag
// - compare match drives output pin to the output level bit
// - counter advances once per four clock cycles via fixed prescaler
// - edge select 1 picks rising, 0 picks falling capture edges
module timer_register_access_low_power
   import timer_pkg::*;
#(
   parameter int PRE_DIV = PRESCALE
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdata,
   // pins
   input wire logic capturePin,
   output logic compareOut,
   // low-power control
   input wire logic waitMode,
   input wire logic stopMode,
   input wire logic stopResetExit,
   output logic timerIrq,
   output logic wakeReq
);
   localparam int PW = $clog2(PRE_DIV);
   localparam logic [PW-1:0] PRE_LAST = PW'(PRE_DIV - 1);

   // tick decode relies on the prescaler wrapping by itself
   if (PRE_DIV < 2 || (1 << PW) != PRE_DIV) begin : g_bad_div
      $error("prescale must be a power of two of at least 2");
   end

   function automatic logic rdHit(input logic rd, input logic [7:0] a,
                                  input logic [7:0] ofs);
      rdHit = rd && (a == ofs);
   endfunction

   logic rstMeta_ff;
   logic rstSync_ff;
   logic rst_n;
   logic [PW-1:0] pre_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [7:0] ctrl_ff;
   logic ovfFlag_ff;
   logic capFlag_ff;
   logic cmpFlag_ff;
   logic ovfSeen_ff;
   logic capSeen_ff;
   logic cmpSeen_ff;
   logic [7:0] cntLoHold_ff;
   logic cntLoFrozen_ff;
   logic [7:0] altLoHold_ff;
   logic altLoFrozen_ff;
   logic [CNT_W-1:0] cap_ff;
   logic capBlock_ff;
   logic [CNT_W-1:0] cmp_ff;
   logic cmpBlock_ff;
   logic capPrev_ff;
   logic stopPrev_ff;
   logic capLive_ff;
   logic armed_ff;
   logic [CNT_W-1:0] armVal_ff;
   logic compareOut_ff;
   logic [7:0] rdata_ff;

   logic tick;
   logic wrap;
   logic match;
   logic capEdge;
   logic capTake;
   logic stopExitIrq;
   logic rdStatus;
   logic rdCntHi;
   logic rdCntLo;
   logic rdAltHi;
   logic rdAltLo;
   logic rdCapHi;
   logic rdCapLo;
   logic rdCmpLo;
   logic wrCtrl;
   logic wrCmpHi;
   logic wrCmpLo;
   logic [7:0] statusVal;
   logic [7:0] nxt_rdata;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta_ff <= 1'b0;
         rstSync_ff <= 1'b0;
      end else begin
         rstMeta_ff <= 1'b1;
         rstSync_ff <= rstMeta_ff;
      end
   end
   assign rst_n = rstSync_ff;

   assign rdStatus = rdHit(regRd, regAddr, OFS_STATUS);
   assign rdCntHi = rdHit(regRd, regAddr, OFS_CNT_HI);
   assign rdCntLo = rdHit(regRd, regAddr, OFS_CNT_LO);
   assign rdAltHi = rdHit(regRd, regAddr, OFS_ALT_HI);
   assign rdAltLo = rdHit(regRd, regAddr, OFS_ALT_LO);
   assign rdCapHi = rdHit(regRd, regAddr, OFS_CAP_HI);
   assign rdCapLo = rdHit(regRd, regAddr, OFS_CAP_LO);
   assign rdCmpLo = rdHit(regRd, regAddr, OFS_CMP_LO);
   // counter, alternate and capture bytes have no write decode at all
   assign wrCtrl = regWr && (regAddr == OFS_CTRL);
   assign wrCmpHi = regWr && (regAddr == OFS_CMP_HI);
   assign wrCmpLo = regWr && (regAddr == OFS_CMP_LO);

   // prescaler runs in wait, halts in stop
   assign tick = (pre_ff == PRE_LAST) && !stopMode;
   assign wrap = tick && (cnt_ff == CNT_MAX);
   assign match = tick && !cmpBlock_ff && (cnt_ff == cmp_ff);
   assign capEdge = capLive_ff && (ctrl_ff[CTRL_EDGE] ? (capturePin && !capPrev_ff)
                                                     : (!capturePin && capPrev_ff));
   assign capTake = capEdge && !stopMode && !capBlock_ff;
   // stop dropping without the reset pulse counts as an interrupt exit
   assign stopExitIrq = stopPrev_ff && !stopMode && !stopResetExit;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_ff <= '0;
      end else if (stopResetExit) begin
         pre_ff <= '0;
      end else if (!stopMode) begin
         pre_ff <= pre_ff + PW'(1);
      end
   end

   // reset-exit reload works whether or not stop has already dropped
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= CNT_RESET;
      end else if (stopResetExit) begin
         cnt_ff <= CNT_RESET;
      end else if (tick) begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end

   // edge select resets to falling; software picks polarity before use
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= CTRL_RESET;
      end else if (wrCtrl) begin
         ctrl_ff <= regWdata;
      end
   end

   // status snapshot: which flags software saw set
   // a later status read overwrites what was recorded
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovfSeen_ff <= 1'b0;
         capSeen_ff <= 1'b0;
         cmpSeen_ff <= 1'b0;
      end else begin
         if (rdStatus) begin
            ovfSeen_ff <= ovfFlag_ff;
         end else if (rdCntLo) begin
            ovfSeen_ff <= 1'b0;
         end
         if (rdStatus) begin
            capSeen_ff <= capFlag_ff;
         end else if (rdCapLo) begin
            capSeen_ff <= 1'b0;
         end
         if (rdStatus) begin
            cmpSeen_ff <= cmpFlag_ff;
         end else if (rdCmpLo || wrCmpLo) begin
            cmpSeen_ff <= 1'b0;
         end
      end
   end

   // flags: a new event in the clearing cycle keeps the flag set
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovfFlag_ff <= 1'b0;
      end else if (wrap) begin
         ovfFlag_ff <= 1'b1;
      end else if (rdCntLo && ovfSeen_ff) begin
         ovfFlag_ff <= 1'b0;
      end
   end
   // alternate low read deliberately absent from the clear term above

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         capFlag_ff <= 1'b0;
      end else if (capTake || (stopExitIrq && armed_ff)) begin
         capFlag_ff <= 1'b1;
      end else if (rdCapLo && capSeen_ff) begin
         capFlag_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmpFlag_ff <= 1'b0;
      end else if (match) begin
         cmpFlag_ff <= 1'b1;
      end else if ((rdCmpLo || wrCmpLo) && cmpSeen_ff) begin
         cmpFlag_ff <= 1'b0;
      end
   end

   // coherent low-byte snapshots
   // a repeated high read simply takes a fresh snapshot
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cntLoHold_ff <= 8'h00;
         cntLoFrozen_ff <= 1'b0;
      end else if (rdCntHi) begin
         cntLoHold_ff <= cnt_ff[7:0];
         cntLoFrozen_ff <= 1'b1;
      end else if (rdCntLo) begin
         cntLoFrozen_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         altLoHold_ff <= 8'h00;
         altLoFrozen_ff <= 1'b0;
      end else if (rdAltHi) begin
         altLoHold_ff <= cnt_ff[7:0];
         altLoFrozen_ff <= 1'b1;
      end else if (rdAltLo) begin
         altLoFrozen_ff <= 1'b0;
      end
   end

   // capture path; no edge is judged until one real pin sample is held,
   // since the idle level of the pin after reset is not known
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         capPrev_ff <= 1'b0;
         capLive_ff <= 1'b0;
         stopPrev_ff <= 1'b0;
      end else begin
         capPrev_ff <= capturePin;
         capLive_ff <= 1'b1;
         stopPrev_ff <= stopMode;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         capBlock_ff <= 1'b0;
      end else if (rdCapHi) begin
         capBlock_ff <= 1'b1;
      end else if (rdCapLo) begin
         capBlock_ff <= 1'b0;
      end
   end

   // only the first edge in stop is kept; no flag until exit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_ff <= 1'b0;
         armVal_ff <= '0;
      end else if (stopResetExit) begin
         armed_ff <= 1'b0;
      end else if (stopMode && capEdge && !armed_ff) begin
         armed_ff <= 1'b1;
         armVal_ff <= cnt_ff;
      end else if (!stopMode) begin
         armed_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_ff <= '0;
      end else if (stopExitIrq && armed_ff) begin
         cap_ff <= armVal_ff;
      end else if (capTake) begin
         cap_ff <= cnt_ff;
      end
   end

   // compare path
   // high write parks matching, so a half-written value never fires
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_ff <= CMP_RESET;
         cmpBlock_ff <= 1'b0;
      end else if (wrCmpHi) begin
         cmp_ff[15:8] <= regWdata;
         cmpBlock_ff <= 1'b1;
      end else if (wrCmpLo) begin
         cmp_ff[7:0] <= regWdata;
         cmpBlock_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         compareOut_ff <= 1'b0;
      end else if (match) begin
         compareOut_ff <= ctrl_ff[CTRL_LEVEL];
      end
   end
   assign compareOut = compareOut_ff;

   // read mux, registered so data lands one cycle after the strobe
   always_comb begin
      statusVal = 8'h00;
      statusVal[STAT_CAP] = capFlag_ff;
      statusVal[STAT_CMP] = cmpFlag_ff;
      statusVal[STAT_OVF] = ovfFlag_ff;
      case (regAddr)
         OFS_CTRL: nxt_rdata = ctrl_ff;
         OFS_STATUS: nxt_rdata = statusVal;
         OFS_CAP_HI: nxt_rdata = cap_ff[15:8];
         OFS_CAP_LO: nxt_rdata = cap_ff[7:0];
         OFS_CMP_HI: nxt_rdata = cmp_ff[15:8];
         OFS_CMP_LO: nxt_rdata = cmp_ff[7:0];
         OFS_CNT_HI: nxt_rdata = cnt_ff[15:8];
         OFS_CNT_LO: nxt_rdata = cntLoFrozen_ff ? cntLoHold_ff : cnt_ff[7:0];
         OFS_ALT_HI: nxt_rdata = cnt_ff[15:8];
         OFS_ALT_LO: nxt_rdata = altLoFrozen_ff ? altLoHold_ff : cnt_ff[7:0];
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else if (regRd) begin
         rdata_ff <= nxt_rdata;
      end
   end
   assign regRdata = rdata_ff;

   // no flag sets in stop, so no event raises the request there: armed capture raises no flag
   assign timerIrq = (capFlag_ff && ctrl_ff[CTRL_CAP_IE])
                   || (cmpFlag_ff && ctrl_ff[CTRL_CMP_IE])
                   || (ovfFlag_ff && ctrl_ff[CTRL_OVF_IE]);
   assign wakeReq = waitMode && timerIrq;
endmodule

//--- pkg/timer_pkg.sv
// constants for the capture/compare timer byte access block
package timer_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CNT_W = 16;
   // register offsets
   localparam logic [7:0] OFS_CTRL = 8'h12;
   localparam logic [7:0] OFS_STATUS = 8'h13;
   localparam logic [7:0] OFS_CAP_HI = 8'h14;
   localparam logic [7:0] OFS_CAP_LO = 8'h15;
   localparam logic [7:0] OFS_CMP_HI = 8'h16;
   localparam logic [7:0] OFS_CMP_LO = 8'h17;
   localparam logic [7:0] OFS_CNT_HI = 8'h18;
   localparam logic [7:0] OFS_CNT_LO = 8'h19;
   localparam logic [7:0] OFS_ALT_HI = 8'h1a;
   localparam logic [7:0] OFS_ALT_LO = 8'h1b;
   // control register fields
   localparam int CTRL_CAP_IE = 7;
   localparam int CTRL_CMP_IE = 6;
   localparam int CTRL_OVF_IE = 5;
   localparam int CTRL_EDGE = 1;
   localparam int CTRL_LEVEL = 0;
   // status register fields
   localparam int STAT_CAP = 7;
   localparam int STAT_CMP = 6;
   localparam int STAT_OVF = 5;
   // reset and timing values
   localparam logic [15:0] CNT_RESET = 16'hfffc;
   localparam logic [15:0] CMP_RESET = 16'hffff;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int PRESCALE = 4;
endpackage

//--- bench/capture_source.sv
// stand-in for the external event line feeding the capture pin
`timescale 1ns/1ps
module capture_source (
   // clock
   input wire logic core_clk,
   // request and pin
   input wire logic wantHigh,
   output logic capturePin = 1'b1
);
   // moves just after the edge, like an already synchronised line
   always @(posedge core_clk) capturePin <= wantHigh;
endmodule

//--- bench/timer_access_sva.sv
// concurrent checks on the timer register port, pins and low-power inputs
`timescale 1ns/1ps
module timer_access_sva
   import timer_pkg::*;
#(
   parameter int PRE_DIV = PRESCALE
) (
   // clock, reset and register port
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [DATA_W-1:0] regRdata,
   // pins and low-power control
   input wire logic capturePin,
   input wire logic compareOut,
   input wire logic waitMode,
   input wire logic stopMode,
   input wire logic stopResetExit,
   input wire logic timerIrq,
   input wire logic wakeReq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // stop keeps ticks and flag sets away, so flag clears are exact
   sequence rd_at(logic [7:0] a);
      stopMode && regRd && regAddr == a;
   endsequence
   sequence wr_at(logic [7:0] a);
      stopMode && regWr && regAddr == a;
   endsequence
   property flag_clear(logic [7:0] lo, int b);
      rd_at(OFS_STATUS) ##1 (regRdata[b] ##0 rd_at(lo)) ##1 rd_at(OFS_STATUS)
      |=> !regRdata[b];
   endproperty
   a_data_holds: assert property (!$past(regRd) |-> $stable(regRdata))
      else $error("read data moved without a read");
   a_ovf_clear: assert property (flag_clear(OFS_CNT_LO, STAT_OVF))
      else $error("overflow flag not cleared");
   a_alt_keeps_ovf: assert property (rd_at(OFS_STATUS)
      ##1 (regRdata[STAT_OVF] ##0 rd_at(OFS_ALT_LO)) ##1 rd_at(OFS_STATUS)
      |=> regRdata[STAT_OVF]) else $error("alternate low read cleared overflow");
   a_cap_clear: assert property (flag_clear(OFS_CAP_LO, STAT_CAP))
      else $error("capture flag not cleared");
   a_cmp_rd_clear: assert property (flag_clear(OFS_CMP_LO, STAT_CMP))
      else $error("compare flag not cleared by read");
   a_cmp_wr_clear: assert property (rd_at(OFS_STATUS)
      ##1 (regRdata[STAT_CMP] ##0 wr_at(OFS_CMP_LO)) ##1 rd_at(OFS_STATUS)
      |=> !regRdata[STAT_CMP]) else $error("compare flag not cleared by write");
   a_stop_pin_holds: assert property ($past(stopMode) |-> $stable(compareOut))
      else $error("compare pin moved in stop");
   a_reset_exit_load: assert property ((stopMode && stopResetExit)
      ##1 rd_at(OFS_ALT_HI) ##1 rd_at(OFS_ALT_LO)
      |-> regRdata == CNT_RESET[15:8] ##1 regRdata == CNT_RESET[7:0])
      else $error("counter not reloaded on reset exit");
   a_stop_no_irq: assert property ($past(stopMode) && !$past(regWr)
      |-> !$rose(timerIrq)) else $error("interrupt raised in stop");
   a_wake_follows: assert property (wakeReq == (waitMode && timerIrq))
      else $error("wake request wrong");
endmodule

bind timer_register_access_low_power timer_access_sva #(.PRE_DIV(PRE_DIV)) i_timer_access_sva (
   .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .capturePin(capturePin),
   .compareOut(compareOut), .waitMode(waitMode), .stopMode(stopMode),
   .stopResetExit(stopResetExit), .timerIrq(timerIrq), .wakeReq(wakeReq));

//--- bench/test_timer_register_access_low_power.sv
// self-checking bench for the timer byte access block
`timescale 1ns/1ps
module test_timer_register_access_low_power import timer_pkg::*;;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdata;
   logic capturePin;
   logic compareOut;
   logic timerIrq;
   logic wakeReq;
   logic waitMode = 1'b0;
   logic stopMode = 1'b0;
   logic stopResetExit = 1'b0;
   logic wantHigh = 1'b1;
   int fails = 0;
   int n_compared = 0;
   logic [7:0] h;
   logic [7:0] l;
   logic [7:0] v;
   always #10 core_clk = ~core_clk;
   timer_register_access_low_power i_timer_register_access_low_power (
      .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .capturePin(capturePin),
      .compareOut(compareOut), .waitMode(waitMode), .stopMode(stopMode),
      .stopResetExit(stopResetExit), .timerIrq(timerIrq), .wakeReq(wakeReq));
   capture_source i_capture_source (.core_clk(core_clk), .wantHigh(wantHigh),
      .capturePin(capturePin));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // tasks start just after an edge, so back-to-back strobes need no gap
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      rd(a, v);
      chk(v, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
      #1;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic rex;
      stopResetExit <= 1'b1;
      @(posedge core_clk);
      stopResetExit <= 1'b0;
      #1;
   endtask
   task automatic t_wait;
      wr(OFS_CAP_LO, 8'h5a);
      rdc(OFS_CAP_LO, 8'h00);
      waitMode <= 1'b1;
      wr(OFS_CTRL, 8'ha0);
      cyc(40);
      chk({7'h0, wakeReq}, 8'h01);
      stopMode <= 1'b1;
      cyc(2);
      rdc(OFS_STATUS, 8'h60);
      rd(OFS_ALT_LO, v);
      rdc(OFS_STATUS, 8'h60);
      rd(OFS_CNT_LO, v);
      rdc(OFS_STATUS, 8'h40);
      chk({7'h0, wakeReq}, 8'h00);
      waitMode <= 1'b0;
   endtask
   task automatic t_frozen;
      rd(OFS_ALT_HI, h);
      rd(OFS_ALT_LO, l);
      wr(OFS_CNT_HI, 8'h12);
      wr(OFS_ALT_LO, 8'h34);
      wr(8'h00, 8'h56);
      cyc(20);
      rdc(OFS_ALT_HI, h);
      rdc(OFS_ALT_LO, l);
      rdc(8'h00, 8'h00);
      rdc(OFS_CNT_HI, h);
      rd(OFS_ALT_HI, v);
      stopMode <= 1'b0;
      cyc(40);
      rdc(OFS_CNT_LO, l);
      rdc(OFS_ALT_LO, l);
   endtask
   task automatic t_cap_stop;
      stopMode <= 1'b1;
      cyc(2);
      rd(OFS_ALT_HI, h);
      rd(OFS_ALT_LO, l);
      wantHigh <= 1'b0;
      cyc(4);
      rdc(OFS_STATUS, 8'h40);
      chk({7'h0, timerIrq}, 8'h00);
      stopMode <= 1'b0;
      cyc(2);
      stopMode <= 1'b1;
      cyc(2);
      rdc(OFS_CAP_HI, h);
      rdc(OFS_STATUS, 8'hc0);
      chk({7'h0, timerIrq}, 8'h01);
      rdc(OFS_CAP_LO, l);
      rdc(OFS_STATUS, 8'h40);
      rd(OFS_CMP_LO, v);
      rdc(OFS_STATUS, 8'h00);
      wantHigh <= 1'b1;
      cyc(3);
      wantHigh <= 1'b0;
      cyc(3);
      rex;
      rdc(OFS_ALT_HI, CNT_RESET[15:8]);
      rdc(OFS_ALT_LO, CNT_RESET[7:0]);
      stopMode <= 1'b0;
      cyc(2);
      rdc(OFS_STATUS, 8'h00);
      rdc(OFS_CAP_LO, l);
   endtask
   task automatic t_compare;
      stopMode <= 1'b1;
      rex;
      wr(OFS_CTRL, 8'h03);
      wr(OFS_CMP_HI, 8'h00);
      rd(OFS_STATUS, v);
      wr(OFS_CMP_LO, 8'h02);
      stopMode <= 1'b0;
      cyc(16);
      chk({7'h0, compareOut}, 8'h00);
      cyc(24);
      chk({7'h0, compareOut}, 8'h01);
      stopMode <= 1'b1;
      cyc(2);
      rdc(OFS_STATUS, 8'h60);
      wr(OFS_CMP_LO, 8'h02);
      rdc(OFS_STATUS, 8'h20);
      wr(OFS_CTRL, 8'h02);
      wr(OFS_CMP_HI, 8'h00);
      rex;
      stopMode <= 1'b0;
      cyc(40);
      chk({7'h0, compareOut}, 8'h01);
      rdc(OFS_STATUS, 8'h20);
      wr(OFS_CMP_HI, 8'h00);
      wr(OFS_CMP_LO, 8'h0a);
      cyc(24);
      chk({7'h0, compareOut}, 8'h00);
      rdc(OFS_STATUS, 8'h60);
   endtask
   task automatic t_cap_run;
      wantHigh <= 1'b1;
      cyc(3);
      rdc(OFS_STATUS, 8'he0);
      rd(OFS_CAP_HI, h);
      rd(OFS_CAP_LO, l);
      rd(OFS_CAP_HI, v);
      wantHigh <= 1'b0;
      cyc(12);
      wantHigh <= 1'b1;
      cyc(12);
      rdc(OFS_CAP_LO, l);
      wantHigh <= 1'b0;
      cyc(12);
      rdc(OFS_CAP_LO, l);
   endtask
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      t_wait;
      t_frozen;
      t_cap_stop;
      t_compare;
      t_cap_run;
      wrap_up;
   end
   // whole run is well under a thousand cycles
   initial begin
      #100us;
      fails++;
      wrap_up;
   end
endmodule
